// >>> hdl/sync_detect_pkg.sv
// package: constants and carrier structs for the frame-sync detector
package sync_detect_pkg;
  // ---------------------------------------------------------------
  // delay line
  // ---------------------------------------------------------------
  localparam int DELAY_STAGES = 8;
  localparam int CH1_TAP = 0;
  localparam int CH9_TAP = 7;
  localparam logic RESET_LEVEL = 1'b0;
  // ---------------------------------------------------------------
  // variant encoding
  // ---------------------------------------------------------------
  typedef enum logic {
    VARIANT_VIB = 1'b0,
    VARIANT_GA = 1'b1
  } variant_e;
  // ---------------------------------------------------------------
  // carrier structs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sync;
    logic clr;
    logic keying;
    logic main_sync;
    logic cmp_in;
  } sync_in_s;
  typedef struct packed {
    logic buf_true;
    logic buf_comp;
    logic delayed_tap_a;
    logic delayed_tap_b;
    logic lag_true;
    logic lag_comp;
    logic cmp_pulse;
    logic gate_sync;
    logic countdown;
    logic key_pulse;
  } sync_out_s;
endpackage : sync_detect_pkg

// >>> hdl/sync_pattern_detector.sv
// file: frame-sync delay line, one-bit comparator and programmer
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - delay line repeats the sync stream eight channel clocks later
// - buffer stage gives true and complement levels aligned with each sync
// - each stage loads one on sync present, zero otherwise, every clock that clr is low
// - stage n lags the buffer stage by n clock periods
// - delayed output leaves on one tap for vibration, another for G-A
// - comparator pulses when two syncs arrive one clock apart
// - comparator pulses when two delay-line pulses coincide
// - comparator stage gives sync copy, true and complement, one clock late
// - first coincidence gate pulses on the channel 1 sync
// - second coincidence gate pulses on the channel 9 sync
// - both coincidences are ORed on one summing node
// - comparator output follows each combined channel 1 or 9 pulse
// - programmer gates delay output with comparator input toward sync gate
// - programmer provides divide-by-two countdown from a flip-flop
// - keying flip-flop driven by keying input and main frame sync
module sync_pattern_detector #(
  parameter int STAGES = 8
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire sync_detect_pkg::sync_in_s ctl_in,
  input wire sync_detect_pkg::variant_e variant_in,
  output var sync_detect_pkg::sync_out_s stat_out
);
  import sync_detect_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic buf_q;
    logic [STAGES-1:0] chain;
    logic lag_q;
    sync_out_s out;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic ch1_hit;
  logic ch9_hit;
  logic sum_node;
  logic delayed;

  // ---------------------------------------------------------------
  // tap decode
  // ---------------------------------------------------------------
  function automatic logic tap_on(input variant_e sel, input variant_e tap);
    return sel == tap;
  endfunction : tap_on

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // buffer stage loads one on sync, zero otherwise
    state_next.buf_q = ctl_in.sync;
    state_next.chain = {state_reg.chain[STAGES-2:0], state_reg.buf_q};
    state_next.lag_q = ctl_in.sync;
    delayed = state_reg.chain[STAGES-1];
    // pulses one clock apart: current sync and its one-clock copy
    ch1_hit = ctl_in.sync & state_reg.lag_q;
    // coincidence of two delay-line taps
    ch9_hit = state_reg.chain[CH1_TAP] & state_reg.chain[CH9_TAP];
    sum_node = ch1_hit | ch9_hit;
    // output copies load with the buffer and lag flops, same edge
    state_next.out.buf_true = ctl_in.sync;
    state_next.out.buf_comp = ~ctl_in.sync;
    state_next.out.lag_true = ctl_in.sync;
    state_next.out.lag_comp = ~ctl_in.sync;
    state_next.out.delayed_tap_a = tap_on(variant_in, VARIANT_VIB) & delayed;
    state_next.out.delayed_tap_b = tap_on(variant_in, VARIANT_GA) & delayed;
    state_next.out.cmp_pulse = sum_node;
    state_next.out.gate_sync = delayed & ctl_in.cmp_in;
    if (ctl_in.sync) begin
      state_next.out.countdown = ~state_reg.out.countdown;
    end
    // main frame sync clears the key, keying input sets it
    if (ctl_in.main_sync) begin
      state_next.out.key_pulse = 1'b0;
    end else if (ctl_in.keying) begin
      state_next.out.key_pulse = 1'b1;
    end
    // separate clear input from the controller
    if (ctl_in.clr) begin
      state_next.buf_q = RESET_LEVEL;
      state_next.chain = '0;
      state_next.lag_q = RESET_LEVEL;
      state_next.out.buf_true = RESET_LEVEL;
      state_next.out.buf_comp = ~RESET_LEVEL;
      state_next.out.lag_true = RESET_LEVEL;
      state_next.out.lag_comp = ~RESET_LEVEL;
    end
  end

  // ---------------------------------------------------------------
  // registers, one edge for every stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= '0;
      state_reg.out.buf_comp <= 1'b1;
      state_reg.out.lag_comp <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign stat_out = state_reg.out;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  delay_eight_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in, 1) && !$past(sys_rst_in, 2) && !$past(sys_rst_in, 3) &&
    !$past(sys_rst_in, 4) && !$past(sys_rst_in, 5) && !$past(sys_rst_in, 6) &&
    !$past(sys_rst_in, 7) && !$past(sys_rst_in, 8) && !$past(sys_rst_in, 9) &&
    $past(ctl_in.clr, 1) == 1'b0 &&
    $past(ctl_in.clr, 2) == 1'b0 && $past(ctl_in.clr, 3) == 1'b0 &&
    $past(ctl_in.clr, 4) == 1'b0 && $past(ctl_in.clr, 5) == 1'b0 &&
    $past(ctl_in.clr, 6) == 1'b0 && $past(ctl_in.clr, 7) == 1'b0 &&
    $past(ctl_in.clr, 8) == 1'b0 && $past(ctl_in.clr, 9) == 1'b0 &&
    $past(ctl_in.sync, 9) |-> state_reg.chain[STAGES-1])
    else $error("delay line lost sync");
  buf_comp_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    stat_out.buf_true != stat_out.buf_comp)
    else $error("buffer levels not complementary");
  stage_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.clr |=> state_reg.buf_q == $past(ctl_in.sync))
    else $error("buffer stage load wrong");
  stage_lag_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.clr |=> state_reg.chain[1] == $past(state_reg.chain[0]))
    else $error("stage lag wrong");
  clear_chain_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_in.clr |=> state_reg.chain == '0)
    else $error("clear did not empty chain");
  tap_select_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(stat_out.delayed_tap_a && stat_out.delayed_tap_b))
    else $error("both taps active");
  adjacent_sync_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_in.sync ##1 ctl_in.sync |=> stat_out.cmp_pulse)
    else $error("adjacent syncs missed");
  key_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_in.main_sync |=> !stat_out.key_pulse)
    else $error("main sync did not clear key");
  countdown_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_in.sync |=> stat_out.countdown != $past(stat_out.countdown))
    else $error("countdown did not toggle");
  first_stage_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.clr |=> state_reg.chain[0] == $past(state_reg.buf_q))
    else $error("first stage lag wrong");
  chain_shift_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.clr |=>
    state_reg.chain[STAGES-1:1] == $past(state_reg.chain[STAGES-2:0]))
    else $error("chain shift wrong");
  clear_stages_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_in.clr |=> !state_reg.buf_q && !state_reg.lag_q)
    else $error("clear did not empty buffer");
  clear_outs_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_in.clr |=> !stat_out.buf_true && !stat_out.lag_true)
    else $error("clear did not drop copies");
  buf_follow_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.clr |=> stat_out.buf_true == $past(ctl_in.sync))
    else $error("buffer copy wrong");
  buf_inverse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.clr |=> stat_out.buf_comp == !$past(ctl_in.sync))
    else $error("buffer complement wrong");
  tap_vib_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    variant_in == VARIANT_VIB |=>
    stat_out.delayed_tap_a == $past(state_reg.chain[STAGES-1]))
    else $error("vibration tap wrong");
  tap_ga_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    variant_in == VARIANT_GA |=>
    stat_out.delayed_tap_b == $past(state_reg.chain[STAGES-1]))
    else $error("other tap wrong");
  tap_a_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    variant_in == VARIANT_GA |=> !stat_out.delayed_tap_a)
    else $error("tap a active in other variant");
  tap_b_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    variant_in == VARIANT_VIB |=> !stat_out.delayed_tap_b)
    else $error("tap b active in vibration variant");
  // ---------------------------------------------------------------
  // comparator checks
  // ---------------------------------------------------------------
  lag_copy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.clr |=> stat_out.lag_true == $past(ctl_in.sync))
    else $error("lag copy wrong");
  lag_inverse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    stat_out.lag_true != stat_out.lag_comp)
    else $error("lag levels not complementary");
  ch1_coinc_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_in.sync && state_reg.lag_q |=> stat_out.cmp_pulse)
    else $error("channel 1 coincidence missed");
  ch9_coinc_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    state_reg.chain[CH1_TAP] && state_reg.chain[CH9_TAP] |=>
    stat_out.cmp_pulse)
    else $error("channel 9 coincidence missed");
  sum_quiet_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(ctl_in.sync && state_reg.lag_q) &&
    !(state_reg.chain[CH1_TAP] && state_reg.chain[CH9_TAP]) |=>
    !stat_out.cmp_pulse)
    else $error("comparator pulse without coincidence");
  // ---------------------------------------------------------------
  // programmer checks
  // ---------------------------------------------------------------
  gate_sync_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    1'b1 |=> stat_out.gate_sync ==
    $past(state_reg.chain[STAGES-1] & ctl_in.cmp_in))
    else $error("gated sync wrong");
  gate_block_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.cmp_in |=> !stat_out.gate_sync)
    else $error("gated sync without comparator input");
  countdown_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.sync |=> stat_out.countdown == $past(stat_out.countdown))
    else $error("countdown moved without sync");
  key_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.main_sync && ctl_in.keying |=> stat_out.key_pulse)
    else $error("keying did not set key");
  key_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ctl_in.main_sync && !ctl_in.keying |=>
    stat_out.key_pulse == $past(stat_out.key_pulse))
    else $error("key moved without input");
  key_priority_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctl_in.main_sync && ctl_in.keying |=> !stat_out.key_pulse)
    else $error("keying beat main sync");
endmodule : sync_pattern_detector
`default_nettype wire

// >>> testbench/sync_source.sv
// upstream sync source model: one pulse per requested interval
`timescale 1ns/10ps
`default_nettype none
module sync_source (
  input wire logic clk_in,
  input wire logic req_in,
  output var logic sync_out
);
  initial sync_out = 1'b0;
  always @(posedge clk_in) begin
    sync_out <= #1 req_in;
  end
endmodule : sync_source
`default_nettype wire

// >>> testbench/tb_top.sv
// testbench: frame-sync detector scenarios
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sync_detect_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req = 1'b0;
  logic clr = 1'b0;
  logic key = 1'b0;
  logic msync = 1'b0;
  logic cmp = 1'b0;
  logic cd = 1'b0;
  logic sync_w;
  sync_in_s ctl_in;
  variant_e variant_in = VARIANT_VIB;
  sync_out_s stat_out;
  int failures = 0;
  int checked = 0;
  assign ctl_in = {sync_w, clr, key, msync, cmp};
  sync_source i_src (.clk_in(clk_in), .req_in(req), .sync_out(sync_w));
  sync_pattern_detector i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .ctl_in(ctl_in), .variant_in(variant_in), .stat_out(stat_out));
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  task automatic chk(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic fire(input int n);
    req = 1'b1;
    cd ^= n[0];
    step(n);
    req = 1'b0;
  endtask : fire
  task automatic t_delay(input variant_e v);
    variant_in = v;
    cmp = (v == VARIANT_GA);
    fire(1);
    step(1);
    chk("buf_true", 1'b1, stat_out.buf_true);
    chk("buf_comp", 1'b0, stat_out.buf_comp);
    chk("lag_true", 1'b1, stat_out.lag_true);
    chk("lag_comp", 1'b0, stat_out.lag_comp);
    chk("countdown", cd, stat_out.countdown);
    step(1);
    chk("buf_idle", 1'b0, stat_out.buf_true);
    step(7);
    chk("tap_early", 1'b0,
        stat_out.delayed_tap_a | stat_out.delayed_tap_b);
    step(1);
    chk("tap_a", v == VARIANT_VIB, stat_out.delayed_tap_a);
    chk("tap_b", v == VARIANT_GA, stat_out.delayed_tap_b);
    chk("gate_sync", cmp, stat_out.gate_sync);
    step(4);
    $display("delay test done");
  endtask : t_delay
  task automatic t_coinc;
    fire(1);
    step(6);
    fire(1);
    step(2);
    chk("cmp_early", 1'b0, stat_out.cmp_pulse);
    step(1);
    chk("cmp_ch9", 1'b1, stat_out.cmp_pulse);
    step(12);
    fire(2);
    step(1);
    chk("cmp_ch1", 1'b1, stat_out.cmp_pulse);
    chk("countdown", cd, stat_out.countdown);
    step(12);
    $display("coincidence test done");
  endtask : t_coinc
  task automatic t_clr;
    fire(1);
    step(2);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(7);
    chk("tap_cleared", 1'b0, stat_out.delayed_tap_a);
    key = 1'b1;
    step(1);
    chk("key_set", 1'b1, stat_out.key_pulse);
    msync = 1'b1;
    step(1);
    chk("key_clear", 1'b0, stat_out.key_pulse);
    key = 1'b0;
    msync = 1'b0;
    $display("clear and key test done");
  endtask : t_clr
  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    step(20);
    sys_rst_in = 1'b0;
    t_delay(VARIANT_GA);
    t_delay(VARIANT_VIB);
    t_coinc();
    t_clr();
    close_out();
  end
  initial begin
    #10000;
    failures++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
